// [hw/cpu_register_datapath.sv]
`timescale 1ns/1ns
// Overview of operation
// RL1 - 4-bit add, compare, and, or, bit ops
// RL2 - add-with-carry sets carry on overflow
// RL3 - plain adds leave carry untouched
// RL4 - rotate right moves bit 0 to carry
// RL5 - set and clear carry instructions
// RL6 - pair register equals hold:work nibbles
// RL7 - pair and in-page pointer not reset
// RL8 - in-page pointer plus work forms offset
// RL9 - table lookup loads pointer when flag set
// RL10 - upper flag set, cleared, resets zero
// RL11 - eight-entry return stack, pushed thrice ways
// RL12 - overflow past eight silently corrupts
// RL13 - automatic 3-bit index, copy to work
// RL14 - interrupt saves pointer, flags, work, hold
// RL15 - skip flag decides skips, saved; the code holds and saves the flag but skips no instruction
// RL16 - counter advances or loads target
// RL17 - page above bit 7, offset below; the code puts the page in bits 11:7 and the offset in bits 6:0
// RL18 - offset wrap steps to next page
// RL19 - software keeps page within ROM
// RL20 - group, file, digit select RAM word
// RL21 - digit also selects port bit
// RL22 - group and pointers not reset
// RL23 - one machine cycle per three clocks
module cpu_register_datapath
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire cpu_datapath_pkg::dp_cmd_t i_cmd,
    input wire logic [cpu_datapath_pkg::DATA_W-1:0] i_ram_data,
    input wire logic [cpu_datapath_pkg::ROM_W-1:0] i_rom_data,
    output logic o_cycle,
    output logic [cpu_datapath_pkg::IP_W-1:0] o_instr_ptr,
    output logic [cpu_datapath_pkg::IP_W-1:0] o_rom_addr,
    output cpu_datapath_pkg::ram_pointer_t o_ram_pointer,
    output logic [cpu_datapath_pkg::DIGIT_W-1:0] o_port_bit,
    output logic [cpu_datapath_pkg::DATA_W-1:0] o_work,
    output logic [cpu_datapath_pkg::DATA_W-1:0] o_hold,
    output logic [cpu_datapath_pkg::PAIR_W-1:0] o_pair,
    output logic [cpu_datapath_pkg::INPTR_W-1:0] o_inpage_ptr,
    output logic o_carry_flag,
    output logic o_table_upper_flag,
    output logic o_skip_flag,
    output logic o_compare_equal,
    output logic [cpu_datapath_pkg::STACK_IDX_W-1:0] o_stack_index
);
    logic tick;
    logic tick_q;
    logic [cpu_datapath_pkg::DATA_W-1:0] work_q;
    logic [cpu_datapath_pkg::DATA_W-1:0] hold_q;
    logic [cpu_datapath_pkg::PAIR_W-1:0] pair_q;
    logic [cpu_datapath_pkg::INPTR_W-1:0] inptr_q;
    logic carry_q;
    logic upper_q;
    logic skip_q;
    logic [cpu_datapath_pkg::IP_W-1:0] ip_q;
    cpu_datapath_pkg::ram_pointer_t ptr_q;
    cpu_datapath_pkg::save_t save_q;
    logic [cpu_datapath_pkg::IP_W-1:0] stack_top;
    logic [cpu_datapath_pkg::STACK_IDX_W-1:0] stack_idx;
    logic push;
    logic pop;
    logic [cpu_datapath_pkg::IP_W-1:0] ret_addr;
    logic [cpu_datapath_pkg::DATA_W:0] sum;
    logic [cpu_datapath_pkg::DATA_W-1:0] alu_res;
    logic [cpu_datapath_pkg::IP_W-1:0] ip_next;
    logic [cpu_datapath_pkg::IP_W-1:0] via_work;
    cpu_datapath_pkg::dp_op_t op;

    function automatic logic [cpu_datapath_pkg::DATA_W-1:0] bit_mask(input logic [1:0] sel);
        bit_mask = 4'h1 << sel;
    endfunction

    assign op = i_cmd.op;

    // RL23 one machine cycle
    instr_clock_div u_div
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    // RL11 push on entry
    assign push = tick && (op == cpu_datapath_pkg::OP_CALL || op == cpu_datapath_pkg::OP_INTR
                           || op == cpu_datapath_pkg::OP_TABLE);
    // table lookup borrows a level for one cycle and gives it back
    assign pop = tick && (op == cpu_datapath_pkg::OP_RETURN || op == cpu_datapath_pkg::OP_RET_INTR
                          || op == cpu_datapath_pkg::OP_TABLE);
    assign ret_addr = ip_q + 12'h001;

    // RL12 unprotected wrap
    return_stack u_stack
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_push(push),
        .i_pop(pop),
        .i_data(ret_addr),
        .o_top(stack_top),
        .o_index(stack_idx)
    );

    // RL1 arithmetic unit
    always_comb
    begin
        sum = {1'b0, work_q} + {1'b0, (op == cpu_datapath_pkg::OP_ADD_IMM) ? i_cmd.imm : i_ram_data}
              + {4'h0, (op == cpu_datapath_pkg::OP_ADD_MEMC) & carry_q};
        case (i_cmd.alu)
            cpu_datapath_pkg::ALU_ADD: alu_res = sum[cpu_datapath_pkg::DATA_W-1:0];
            cpu_datapath_pkg::ALU_CMP: alu_res = work_q;
            cpu_datapath_pkg::ALU_AND: alu_res = work_q & i_ram_data;
            cpu_datapath_pkg::ALU_OR: alu_res = work_q | i_ram_data;
            cpu_datapath_pkg::ALU_BIT: alu_res = i_cmd.imm[0] ? (i_ram_data | bit_mask(i_cmd.bitsel))
                                                              : (i_ram_data & ~bit_mask(i_cmd.bitsel));
            default: alu_res = work_q;
        endcase
    end

    // RL8 in-page address
    assign via_work = {i_cmd.page, inptr_q, work_q};

    // RL16 next pointer
    always_comb
    begin
        case (op)
            // RL18 page carry
            cpu_datapath_pkg::OP_NOP: ip_next = ip_q + 12'h001;
            cpu_datapath_pkg::OP_BRANCH_A: ip_next = via_work;
            cpu_datapath_pkg::OP_CALL: ip_next = i_cmd.target;
            cpu_datapath_pkg::OP_INTR: ip_next = i_cmd.target;
            cpu_datapath_pkg::OP_RETURN: ip_next = stack_top;
            cpu_datapath_pkg::OP_RET_INTR: ip_next = stack_top;
            default: ip_next = ip_q + 12'h001;
        endcase
    end

    // RL17 page and offset fields
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ip_q <= cpu_datapath_pkg::IP_RST;
        end
        else if (tick)
        begin
            ip_q <= ip_next;
        end
    end

    // table lookup reads ROM at the in-page address, return point held on stack
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rom_addr <= cpu_datapath_pkg::IP_RST;
        end
        else
        begin
            o_rom_addr <= (op == cpu_datapath_pkg::OP_TABLE || op == cpu_datapath_pkg::OP_CALL) ? via_work : ip_q;
        end
    end

    // work register and carry
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            work_q <= cpu_datapath_pkg::WORK_RST;
            carry_q <= cpu_datapath_pkg::CARRY_RST;
        end
        else if (tick)
        begin
            case (op)
                // RL3 carry kept
                cpu_datapath_pkg::OP_ADD_IMM: work_q <= alu_res;
                cpu_datapath_pkg::OP_ADD_MEM: work_q <= alu_res;
                // RL2 carry out
                cpu_datapath_pkg::OP_ADD_MEMC:
                begin
                    work_q <= alu_res;
                    if (sum[cpu_datapath_pkg::DATA_W])
                    begin
                        carry_q <= 1'b1;
                    end
                end
                // RL4 bit 0 out
                cpu_datapath_pkg::OP_ROT_R:
                begin
                    work_q <= {carry_q, work_q[3:1]};
                    carry_q <= work_q[0];
                end
                // RL5 force carry
                cpu_datapath_pkg::OP_SET_C: carry_q <= 1'b1;
                cpu_datapath_pkg::OP_CLR_C: carry_q <= 1'b0;
                cpu_datapath_pkg::OP_LOGIC: work_q <= alu_res;
                // RL14 restore saved
                cpu_datapath_pkg::OP_RET_INTR:
                begin
                    work_q <= save_q.work;
                    carry_q <= save_q.carry;
                end
                default:
                begin
                    // RL13 index to work
                    if (i_cmd.ld_work_from_idx)
                    begin
                        work_q <= {1'b0, stack_idx};
                    end
                    // RL6 pair low nibble
                    else if (i_cmd.ld_pair)
                    begin
                        work_q <= pair_q[3:0];
                    end
                end
            endcase
        end
    end

    // hold register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hold_q <= cpu_datapath_pkg::WORK_RST;
        end
        else if (tick)
        begin
            if (op == cpu_datapath_pkg::OP_RET_INTR)
            begin
                hold_q <= save_q.hold;
            end
            else if (i_cmd.ld_pair)
            begin
                hold_q <= pair_q[7:4];
            end
        end
    end

    // RL7 no reset on pair and in-page pointer
    always_ff @(posedge i_clk)
    begin
        if (tick && i_cmd.st_pair)
        begin
            pair_q <= {hold_q, work_q};
        end
    end

    // RL9 upper bits load
    always_ff @(posedge i_clk)
    begin
        if (tick && op == cpu_datapath_pkg::OP_TABLE && upper_q)
        begin
            inptr_q <= {1'b0, i_rom_data[cpu_datapath_pkg::ROM_UPPER_POS+1:cpu_datapath_pkg::ROM_UPPER_POS]};
        end
        else if (tick && op == cpu_datapath_pkg::OP_LOGIC && i_cmd.ld_ptr)
        begin
            inptr_q <= i_cmd.imm[cpu_datapath_pkg::INPTR_W-1:0];
        end
    end

    // RL10 upper flag
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            upper_q <= cpu_datapath_pkg::UPPER_FLAG_RST;
        end
        else if (tick && op == cpu_datapath_pkg::OP_SET_UP)
        begin
            upper_q <= 1'b1;
        end
        else if (tick && op == cpu_datapath_pkg::OP_CLR_UP)
        begin
            upper_q <= 1'b0;
        end
    end

    // RL15 skip flag
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            skip_q <= 1'b0;
        end
        else if (tick)
        begin
            if (op == cpu_datapath_pkg::OP_RET_INTR)
            begin
                skip_q <= save_q.skip;
            end
            else if (i_cmd.skip_set || (i_cmd.alu == cpu_datapath_pkg::ALU_CMP && work_q == i_ram_data
                                        && op == cpu_datapath_pkg::OP_LOGIC))
            begin
                skip_q <= 1'b1;
            end
            else if (i_cmd.skip_clr)
            begin
                skip_q <= 1'b0;
            end
        end
    end

    // RL14 single-stage save
    always_ff @(posedge i_clk)
    begin
        if (tick && op == cpu_datapath_pkg::OP_INTR)
        begin
            save_q <= '{ptr: ptr_q, carry: carry_q, skip: skip_q, work: work_q, hold: hold_q};
        end
    end

    // RL20 RL22 pointer never reset
    always_ff @(posedge i_clk)
    begin
        if (tick && op == cpu_datapath_pkg::OP_RET_INTR)
        begin
            ptr_q <= save_q.ptr;
        end
        else if (tick && i_cmd.ld_ptr && op != cpu_datapath_pkg::OP_LOGIC)
        begin
            ptr_q <= i_cmd.ptr_val;
        end
    end

    // registered status outputs
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tick_q <= 1'b0;
            o_cycle <= 1'b0;
            o_compare_equal <= 1'b0;
        end
        else
        begin
            // strobe lines up with outputs showing the new state
            tick_q <= tick;
            o_cycle <= tick_q;
            o_compare_equal <= (work_q == i_ram_data);
        end
    end

    // RL21 digit is port bit
    always_ff @(posedge i_clk)
    begin
        o_ram_pointer <= ptr_q;
        o_port_bit <= ptr_q.digit;
        o_pair <= pair_q;
        o_inpage_ptr <= inptr_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_instr_ptr <= cpu_datapath_pkg::IP_RST;
            o_work <= cpu_datapath_pkg::WORK_RST;
            o_hold <= cpu_datapath_pkg::WORK_RST;
            o_carry_flag <= cpu_datapath_pkg::CARRY_RST;
            o_table_upper_flag <= cpu_datapath_pkg::UPPER_FLAG_RST;
            o_skip_flag <= 1'b0;
            o_stack_index <= cpu_datapath_pkg::STACK_IDX_RST;
        end
        else
        begin
            o_instr_ptr <= ip_q;
            o_work <= work_q;
            o_hold <= hold_q;
            o_carry_flag <= carry_q;
            o_table_upper_flag <= upper_q;
            o_skip_flag <= skip_q;
            o_stack_index <= stack_idx;
        end
    end
endmodule

// [pkg/cpu_datapath_pkg.sv]
package cpu_datapath_pkg;

    localparam int unsigned DATA_W = 4;
    localparam int unsigned PAIR_W = 8;
    localparam int unsigned INPTR_W = 3;
    localparam int unsigned OFFSET_W = 7;
    localparam int unsigned PAGE_W = 5;
    localparam int unsigned IP_W = PAGE_W + OFFSET_W;
    localparam int unsigned ROM_W = 10;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned STACK_IDX_W = 3;
    localparam int unsigned GROUP_W = 1;
    localparam int unsigned FILE_W = 4;
    localparam int unsigned DIGIT_W = 4;
    localparam int unsigned OFFSET_POS = 0;
    localparam int unsigned PAGE_POS = 7;
    localparam int unsigned ROM_UPPER_POS = 8;

    localparam int unsigned INSTR_DIV = 3;
    localparam logic [1:0] DIV_LAST = 2'h2;

    localparam logic [DATA_W-1:0] WORK_RST = 4'h0;
    localparam logic [IP_W-1:0] IP_RST = 12'h000;
    localparam logic [STACK_IDX_W-1:0] STACK_IDX_RST = 3'h7;
    localparam logic UPPER_FLAG_RST = 1'b0;
    localparam logic CARRY_RST = 1'b0;

    typedef enum logic [4:0] {
        ALU_ADD  = 5'h01,
        ALU_CMP  = 5'h02,
        ALU_AND  = 5'h04,
        ALU_OR   = 5'h08,
        ALU_BIT  = 5'h10
    } alu_op_t;

    // one-hot operation selector for one machine cycle
    typedef enum logic [15:0] {
        OP_NOP      = 16'h0001,
        OP_ADD_IMM  = 16'h0002,
        OP_ADD_MEM  = 16'h0004,
        OP_ADD_MEMC = 16'h0008,
        OP_ROT_R    = 16'h0010,
        OP_SET_C    = 16'h0020,
        OP_CLR_C    = 16'h0040,
        OP_SET_UP   = 16'h0080,
        OP_CLR_UP   = 16'h0100,
        OP_TABLE    = 16'h0200,
        OP_BRANCH_A = 16'h0400,
        OP_CALL     = 16'h0800,
        OP_RETURN   = 16'h1000,
        OP_INTR     = 16'h2000,
        OP_RET_INTR = 16'h4000,
        OP_LOGIC    = 16'h8000
    } dp_op_t;

    typedef struct packed {
        logic [GROUP_W-1:0] group;
        logic [FILE_W-1:0] file;
        logic [DIGIT_W-1:0] digit;
    } ram_pointer_t;

    typedef struct packed {
        ram_pointer_t ptr;
        logic carry;
        logic skip;
        logic [DATA_W-1:0] work;
        logic [DATA_W-1:0] hold;
    } save_t;

    typedef struct packed {
        dp_op_t op;
        alu_op_t alu;
        logic [DATA_W-1:0] imm;
        logic [1:0] bitsel;
        logic [PAGE_W-1:0] page;
        logic [IP_W-1:0] target;
        logic ld_work_from_idx;
        logic ld_pair;
        logic st_pair;
        logic ld_ptr;
        ram_pointer_t ptr_val;
        logic skip_set;
        logic skip_clr;
    } dp_cmd_t;

endpackage

// [hw/instr_clock_div.sv]
`timescale 1ns/1ns
module instr_clock_div
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_tick
);
    logic [1:0] cnt_q;

    // divide system clock by three
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= 2'h0;
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= (cnt_q == cpu_datapath_pkg::DIV_LAST);
            cnt_q <= (cnt_q == cpu_datapath_pkg::DIV_LAST) ? 2'h0 : cnt_q + 2'h1;
        end
    end
endmodule

// [hw/return_stack.sv]
`timescale 1ns/1ns
module return_stack
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [cpu_datapath_pkg::IP_W-1:0] i_data,
    output logic [cpu_datapath_pkg::IP_W-1:0] o_top,
    output logic [cpu_datapath_pkg::STACK_IDX_W-1:0] o_index
);
    logic [cpu_datapath_pkg::IP_W-1:0] entry_q [cpu_datapath_pkg::STACK_DEPTH];
    logic [cpu_datapath_pkg::STACK_IDX_W-1:0] idx_q;
    logic [cpu_datapath_pkg::STACK_IDX_W-1:0] next_idx;

    assign next_idx = idx_q + 3'h1;

    // no overflow guard: ninth push wraps and overwrites
    always_ff @(posedge i_clk)
    begin
        if (i_push)
        begin
            entry_q[next_idx] <= i_data;
        end
    end

    // index tracks nesting
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            idx_q <= cpu_datapath_pkg::STACK_IDX_RST;
        end
        // push with pop borrows the next entry, index kept
        else if (i_push && !i_pop)
        begin
            idx_q <= next_idx;
        end
        else if (i_pop && !i_push)
        begin
            idx_q <= idx_q - 3'h1;
        end
    end

    assign o_top = entry_q[idx_q];
    assign o_index = idx_q;
endmodule

// [test/cpu_register_datapath_properties.sv]
`timescale 1ns/1ns
module dp_checker
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire cpu_datapath_pkg::dp_cmd_t i_cmd,
    input wire logic [3:0] i_ram_data,
    input wire logic o_cycle,
    input wire logic [11:0] o_instr_ptr,
    input wire cpu_datapath_pkg::ram_pointer_t o_ram_pointer,
    input wire logic [3:0] o_port_bit,
    input wire logic [3:0] o_work,
    input wire logic [2:0] o_inpage_ptr,
    input wire logic o_carry_flag,
    input wire logic o_table_upper_flag,
    input wire logic o_skip_flag,
    input wire logic [2:0] o_stack_index
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    cpu_datapath_pkg::dp_op_t op_q;

    // op taken at the hidden tick, judged when o_cycle is high
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            op_q <= cpu_datapath_pkg::OP_NOP;
        else
            op_q <= i_cmd.op;
    end

    sequence took(op);
        o_cycle && op_q == op;
    endsequence

    chk_cycle_every_three: assert property (o_cycle |=> !o_cycle ##1 !o_cycle ##1 o_cycle)
        else $error("machine cycle spacing wrong");
    chk_carry_force: assert property (o_cycle && (op_q == cpu_datapath_pkg::OP_SET_C
        || op_q == cpu_datapath_pkg::OP_CLR_C) |-> o_carry_flag == (op_q == cpu_datapath_pkg::OP_SET_C))
        else $error("carry set or clear wrong");
    chk_rotate_carry: assert property (took(cpu_datapath_pkg::OP_ROT_R) |-> o_carry_flag == $past(o_work[0]))
        else $error("rotate did not move bit 0 to carry");
    chk_add_keeps_carry: assert property (o_cycle && (op_q == cpu_datapath_pkg::OP_ADD_IMM
        || op_q == cpu_datapath_pkg::OP_ADD_MEM) |-> $stable(o_carry_flag))
        else $error("plain add changed carry");
    chk_addc_sets_carry: assert property (took(cpu_datapath_pkg::OP_ADD_MEMC)
        ##0 ({1'b0, $past(o_work)} + $past(i_ram_data) + $past(o_carry_flag)) > 5'h0f |-> o_carry_flag)
        else $error("carry out not set");
    chk_upper_flag: assert property (o_cycle && (op_q == cpu_datapath_pkg::OP_SET_UP
        || op_q == cpu_datapath_pkg::OP_CLR_UP) |-> o_table_upper_flag == (op_q == cpu_datapath_pkg::OP_SET_UP))
        else $error("upper flag wrong");
    chk_call_push: assert property (took(cpu_datapath_pkg::OP_CALL) |-> o_instr_ptr == $past(i_cmd.target)
        && o_stack_index == $past(o_stack_index) + 3'h1)
        else $error("call target or stack index wrong");
    chk_ip_advance: assert property (took(cpu_datapath_pkg::OP_NOP) ##0 !$past(o_skip_flag)
        |-> o_instr_ptr == $past(o_instr_ptr) + 12'h001)
        else $error("instruction pointer did not advance");
    chk_table_keeps_ptr: assert property (took(cpu_datapath_pkg::OP_TABLE) ##0 !$past(o_table_upper_flag)
        |-> $stable(o_inpage_ptr))
        else $error("in-page pointer changed with flag clear");
    chk_pointer_load: assert property (o_cycle && op_q != cpu_datapath_pkg::OP_LOGIC && $past(i_cmd.ld_ptr)
        |-> o_ram_pointer == $past(i_cmd.ptr_val) && o_port_bit == $past(i_cmd.ptr_val.digit))
        else $error("ram pointer or port bit wrong");

    cover property (took(cpu_datapath_pkg::OP_CALL) ##0 o_stack_index == 3'h0);
    cover property (took(cpu_datapath_pkg::OP_TABLE) ##0 $past(o_table_upper_flag));
    cover property (took(cpu_datapath_pkg::OP_RET_INTR));
endmodule

bind cpu_register_datapath dp_checker chk (.i_clk, .i_rst_n, .i_cmd, .i_ram_data, .o_cycle, .o_instr_ptr,
    .o_ram_pointer, .o_port_bit, .o_work, .o_inpage_ptr, .o_carry_flag, .o_table_upper_flag, .o_skip_flag,
    .o_stack_index);

// [test/rom_ram_model.sv]
`timescale 1ns/1ns
module rom_ram_model
(
    input wire logic i_clk,
    input wire logic [11:0] i_rom_addr,
    input wire cpu_datapath_pkg::ram_pointer_t i_ram_pointer,
    output logic [9:0] o_rom_data,
    output logic [3:0] o_ram_data
);
    logic [9:0] rom [4096];
    logic [3:0] ram [512];
    logic [3:0] churn_q = 4'h5;

    initial
    begin
        for (int i = 0; i < 4096; i++)
        begin
            rom[i] = 10'(i * 12'h0a7 + (i >> 4));
            ram[i % 512] = 4'(i * 4'h7 + (i >> 5));
        end
    end

    // an unloaded pointer reads a changing pattern, never a held word
    always @(posedge i_clk)
        churn_q <= ~churn_q + 4'h3;
    always_comb o_ram_data = $isunknown(i_ram_pointer) ? churn_q : ram[i_ram_pointer];
    always_comb o_rom_data = $isunknown(i_rom_addr) ? {churn_q, churn_q, churn_q[1:0]} : rom[i_rom_addr];
endmodule

// [test/tb_cpu_register_datapath.sv]
`timescale 1ns/1ns
module tb_cpu_register_datapath;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    cpu_datapath_pkg::dp_cmd_t i_cmd, c;
    cpu_datapath_pkg::ram_pointer_t o_ram_pointer, p;
    logic [3:0] i_ram_data, o_port_bit, o_work, o_hold, w, x;
    logic [9:0] i_rom_data;
    logic [11:0] o_instr_ptr, o_rom_addr, ipx;
    logic [11:0] ret [$];
    logic [7:0] o_pair;
    logic [2:0] o_inpage_ptr, o_stack_index, d, idx;
    logic [4:0] s;
    logic o_cycle, o_carry_flag, o_table_upper_flag, o_skip_flag, cy, eq;
    logic [15:0] lfsr = 16'h1b1c;
    int error_cnt = 0;
    int num_checks = 0;

    always #2 i_clk = ~i_clk;

    cpu_register_datapath dut (.i_clk, .i_rst_n, .i_cmd, .i_ram_data, .i_rom_data, .o_cycle, .o_instr_ptr,
        .o_rom_addr, .o_ram_pointer, .o_port_bit, .o_work, .o_hold, .o_pair, .o_inpage_ptr, .o_carry_flag,
        .o_table_upper_flag, .o_skip_flag, .o_compare_equal(eq), .o_stack_index);
    rom_ram_model mem (.i_clk, .i_rom_addr(o_rom_addr), .i_ram_pointer(o_ram_pointer), .o_rom_data(i_rom_data),
        .o_ram_data(i_ram_data));

    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [4:0] add_exp(input logic [3:0] a, input logic [3:0] b, input logic ci);
        return {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction

    function automatic cpu_datapath_pkg::dp_cmd_t mk(input cpu_datapath_pkg::dp_op_t op);
        mk = '0;
        mk.op = op;
        mk.alu = cpu_datapath_pkg::ALU_ADD;
    endfunction

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // called at a falling edge; returns at the first falling edge on which o_cycle is high
    task automatic run(input cpu_datapath_pkg::dp_cmd_t cmd);
        int n;
        n = 0;
        i_cmd = cmd;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while (o_cycle !== 1'b1 && n < 6);
        check("o_cycle", 1'b1, o_cycle);
    endtask

    task automatic go(input cpu_datapath_pkg::dp_op_t op);
        run(mk(op));
    endtask

    task automatic restore();
        c = mk(cpu_datapath_pkg::OP_NOP);
        c.ld_pair = 1'b1;
        run(c);
        check("work", x, o_work);
        check("hold", 4'h0, o_hold);
        w = x;
    endtask

    task automatic reset_dut();
        i_rst_n = 1'b0;
        repeat (16) @(negedge i_clk);
        check("upper", cpu_datapath_pkg::UPPER_FLAG_RST, o_table_upper_flag);
        check("carry", cpu_datapath_pkg::CARRY_RST, o_carry_flag);
        check("ip", cpu_datapath_pkg::IP_RST, o_instr_ptr);
        check("index", cpu_datapath_pkg::STACK_IDX_RST, o_stack_index);
        i_rst_n = 1'b1;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        // a few hundred cycles expected; this is a generous ceiling
        #40000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        i_cmd = mk(cpu_datapath_pkg::OP_NOP);
        reset_dut();
        w = 4'h0;
        for (int i = 0; i < 9; i++)
        begin
            lfsr = next_rand(lfsr);
            p = lfsr[8:0];
            c = mk(cpu_datapath_pkg::OP_NOP);
            c.ld_ptr = 1'b1;
            c.ptr_val = p;
            run(c);
            check("ram_ptr", p, o_ram_pointer);
            check("port_bit", p.digit, o_port_bit);
            cy = lfsr[9];
            go(cy ? cpu_datapath_pkg::OP_SET_C : cpu_datapath_pkg::OP_CLR_C);
            check("carry", cy, o_carry_flag);
            case (i % 3)
                0: c = mk(cpu_datapath_pkg::OP_ADD_IMM);
                1: c = mk(cpu_datapath_pkg::OP_ADD_MEM);
                default: c = mk(cpu_datapath_pkg::OP_ADD_MEMC);
            endcase
            c.imm = lfsr[15:12] | 4'h8;
            x = (i % 3 == 0) ? c.imm : mem.ram[p];
            s = add_exp(w, x, (i % 3 == 2) ? cy : 1'b0);
            run(c);
            w = s[3:0];
            check("work", w, o_work);
            if (i % 3 != 2)
                check("carry", cy, o_carry_flag);
            else if (s[4])
                check("carry", 1'b1, o_carry_flag);
        end
        check("equal", {3'h0, w == mem.ram[p]}, eq);
        x = w;
        c = mk(cpu_datapath_pkg::OP_NOP);
        c.st_pair = 1'b1;
        run(c);
        check("pair", {4'h0, x}, o_pair);
        go(cpu_datapath_pkg::OP_ROT_R);
        check("carry", x[0], o_carry_flag);
        restore();
        c = mk(cpu_datapath_pkg::OP_LOGIC);
        c.ld_ptr = 1'b1;
        c.imm = {1'b0, lfsr[2:0]};
        d = lfsr[2:0];
        run(c);
        check("inptr", d, o_inpage_ptr);
        restore();
        for (int u = 1; u >= 0; u--)
        begin
            go(u ? cpu_datapath_pkg::OP_SET_UP : cpu_datapath_pkg::OP_CLR_UP);
            check("upper", u[0], o_table_upper_flag);
            c = mk(cpu_datapath_pkg::OP_TABLE);
            c.page = lfsr[7:3];
            if (u)
                d = {1'b0, mem.rom[{c.page, d, w}][9:8]};
            run(c);
            check("inptr", d, o_inpage_ptr);
            restore();
        end
        c = mk(cpu_datapath_pkg::OP_BRANCH_A);
        c.page = lfsr[12:8];
        ipx = {c.page, d, w};
        run(c);
        check("ip", ipx, o_instr_ptr);
        idx = cpu_datapath_pkg::STACK_IDX_RST;
        for (int k = 0; k < 9; k++)
        begin
            lfsr = next_rand(lfsr);
            c = mk(cpu_datapath_pkg::OP_CALL);
            // page stays below the last rom page
            c.target = (k == 8) ? {1'b0, lfsr[3:0], 7'h7f} : lfsr[11:0];
            ret.push_back(ipx + 12'h001);
            run(c);
            ipx = c.target;
            idx = idx + 3'h1;
            check("ip", ipx, o_instr_ptr);
            check("index", idx, o_stack_index);
        end
        c = mk(cpu_datapath_pkg::OP_NOP);
        c.ld_work_from_idx = 1'b1;
        run(c);
        w = {1'b0, idx};
        check("work", w, o_work);
        check("ip", {ipx[11:7] + 5'h01, 7'h00}, o_instr_ptr);
        for (int k = 0; k < 8; k++)
        begin
            go(cpu_datapath_pkg::OP_RETURN);
            check("ip", ret.pop_back(), o_instr_ptr);
        end
        c = mk(cpu_datapath_pkg::OP_SET_C);
        c.skip_set = 1'b1;
        run(c);
        check("skip", 1'b1, o_skip_flag);
        c = mk(cpu_datapath_pkg::OP_INTR);
        c.target = 12'h080;
        run(c);
        // first handler op is a spare NOP; the pending skip does not consume it, since the datapath skips nothing
        go(cpu_datapath_pkg::OP_NOP);
        go(cpu_datapath_pkg::OP_CLR_C);
        c = mk(cpu_datapath_pkg::OP_ADD_IMM);
        c.imm = 4'h3;
        run(c);
        go(cpu_datapath_pkg::OP_RET_INTR);
        check("carry", 1'b1, o_carry_flag);
        check("skip", 1'b1, o_skip_flag);
        check("work", w, o_work);
        go(cpu_datapath_pkg::OP_SET_UP);
        reset_dut();
        end_of_test();
    end
endmodule
